/* File: hw/cmbm_device.sv */
// message buffer manager: arbitration, serial buffer, matching, lock
`timescale 1ns/1ps
`default_nettype none
module cmbm_device #(
   parameter int NBUF = 4
) (
   input wire logic clk_sys, // system clock
   input wire logic rst, // synchronous reset, active high
   cmbm_bus_if.dev bus, // host register bus
   input wire logic can_idle, // bus free or intermission, same clock
   input wire logic can_id_start, // pulse at identifier start
   output logic tx_valid, // serial buffer holds frame to send
   output logic [28:0] tx_id, // identifier to send
   output logic [3:0] tx_len, // data length, at most eight
   output logic [63:0] tx_data, // data bytes, first in high byte
   input wire logic tx_done, // pulse, frame sent without error
   input wire logic rx_valid, // pulse, error-free frame received
   input wire logic [28:0] rx_id, // received identifier
   input wire logic [3:0] rx_len, // received length
   input wire logic [63:0] rx_data, // received data
   output logic not_ready // not synchronised to bus
);
   localparam int IW = $clog2(NBUF);

   typedef struct packed {
      logic [3:0] code;
      logic [3:0] len;
      logic [28:0] id;
      logic [63:0] data;
      logic [15:0] ts;
   } cmbm_mb_t;

   typedef enum logic [1:0] {TX_IDLE, TX_ARB, TX_COPY, TX_SEND} cmbm_txs_t;

   typedef struct packed {
      cmbm_mb_t [NBUF-1:0] mb;
      logic [NBUF-1:0] flags;
      logic [28:0] amask;
      logic halt;
      logic lowidx;
      logic [3:0] prio;
      logic synced;
      logic [15:0] timer;
      logic [15:0] ts_cap;
      cmbm_txs_t txs;
      logic [IW-1:0] txb;
      logic tx_kill;
      logic [28:0] tx_id;
      logic [3:0] tx_len;
      logic [63:0] tx_data;
      logic rx_pend;
      logic [28:0] rx_id;
      logic [3:0] rx_len;
      logic [63:0] rx_data;
      logic [15:0] rx_ts;
      logic rx_xfer;
      logic [IW-1:0] rx_b;
      logic lock_v;
      logic [IW-1:0] lock_b;
      logic [31:0] rdata;
   } cmbm_st_t;

   cmbm_st_t s_r;
   cmbm_st_t s_nxt;

   // address decode
   logic [7:0] off;
   logic is_mb;
   logic [IW-1:0] ab;
   logic [2:0] af;
   logic ctrl_wr;
   assign off = 8'(bus.addr - cmbm_pkg::A_MB_BASE);
   assign is_mb = (bus.addr >= cmbm_pkg::A_MB_BASE) && (off[7:3] < NBUF);
   assign ab = off[IW+2:3];
   assign af = off[2:0];
   assign ctrl_wr = bus.wr && is_mb && (af == cmbm_pkg::F_CTRL);

   // per-buffer status terms
   logic [NBUF-1:0] tx_pend;
   logic [NBUF-1:0] wsel;
   logic [NBUF-1:0] arb_req;
   logic [NBUF-1:0] rx_hit;
   for (genvar gi = 0; gi < NBUF; gi++) begin : g_mb
      assign tx_pend[gi] = s_r.mb[gi].code == cmbm_pkg::C_TX_ON;
      assign wsel[gi] = ctrl_wr && (ab == IW'(gi));
      // a control write in the selection cycle removes the buffer at once
      assign arb_req[gi] = tx_pend[gi] && !wsel[gi];
      // any active receive code, masked identifier compare
      assign rx_hit[gi] = !s_r.mb[gi].code[3] && (s_r.mb[gi].code[2:1] != 2'b00)
                          && (((s_r.rx_id ^ s_r.mb[gi].id) & s_r.amask) == 29'h0);
   end

   logic tx_any;
   logic [IW-1:0] lo_b;
   logic rx_any;
   logic [IW-1:0] rx_b;
   cmbm_pick #(.N(NBUF)) u_txp (.req(arb_req), .any(tx_any), .idx(lo_b));
   cmbm_pick #(.N(NBUF)) u_rxp (.req(rx_hit), .any(rx_any), .idx(rx_b));

   // lowest identifier among arbitrating buffers, ties to lowest index
   logic [IW-1:0] id_b;
   logic id_hit;
   logic [28:0] best;
   always_comb begin
      id_b = '0;
      id_hit = 1'b0;
      best = '1;
      for (int i = 0; i < NBUF; i++) begin
         if (arb_req[i] && (!id_hit || s_r.mb[i].id < best)) begin
            id_hit = 1'b1;
            id_b = IW'(i);
            best = s_r.mb[i].id;
         end
      end
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.rdata = 32'h0000_0000;
      s_nxt.timer = s_r.timer + 16'h0001;
      if (can_id_start) s_nxt.ts_cap = s_r.timer;
      // software clears flags first so a same-cycle event still sets them
      if (bus.wr && bus.addr == cmbm_pkg::A_FLAGS) s_nxt.flags = s_r.flags & ~bus.wdata[NBUF-1:0];
      // stay unsynchronised while halted, then wait for an idle bus
      if (s_r.halt) s_nxt.synced = 1'b0;
      else if (can_idle) s_nxt.synced = 1'b1;

      // transmit side
      case (s_r.txs)
         TX_IDLE: begin
            if (s_r.synced && !s_r.halt && can_idle && (|tx_pend)) s_nxt.txs = TX_ARB;
         end
         TX_ARB: begin
            if (!tx_any) begin
               s_nxt.txs = TX_IDLE;
            end else begin
               s_nxt.txb = s_r.lowidx ? lo_b : id_b;
               s_nxt.txs = TX_COPY;
            end
         end
         TX_COPY: begin
            s_nxt.tx_id = s_r.mb[s_r.txb].id;
            s_nxt.tx_data = s_r.mb[s_r.txb].data;
            s_nxt.tx_len = (s_r.mb[s_r.txb].len > cmbm_pkg::MAX_BYTES) ?
                           cmbm_pkg::MAX_BYTES : s_r.mb[s_r.txb].len;
            s_nxt.tx_kill = 1'b0;
            // deactivated while copying: drop the frame
            s_nxt.txs = (arb_req[s_r.txb]) ? TX_SEND : TX_IDLE;
         end
         TX_SEND: begin
            if (wsel[s_r.txb]) s_nxt.tx_kill = 1'b1;
            if (tx_done) begin
               s_nxt.txs = TX_IDLE;
               if (!s_r.tx_kill && !wsel[s_r.txb]) begin
                  s_nxt.mb[s_r.txb].ts = s_r.ts_cap;
                  s_nxt.mb[s_r.txb].code = cmbm_pkg::C_TX_OFF;
                  s_nxt.flags[s_r.txb] = 1'b1;
               end
            end
         end
         default: s_nxt.txs = TX_IDLE;
      endcase

      // receive side: two-cycle move from serial buffer, busy in between
      if (s_r.rx_xfer) begin
         s_nxt.rx_xfer = 1'b0;
         s_nxt.mb[s_r.rx_b].code = ((s_r.mb[s_r.rx_b].code & ~cmbm_pkg::C_BUSY) ==
                                    cmbm_pkg::C_RX_EMPTY) ? cmbm_pkg::C_RX_FULL :
                                   cmbm_pkg::C_RX_OVR;
         s_nxt.flags[s_r.rx_b] = 1'b1;
      end else if (s_r.rx_pend) begin
         if (!rx_any) begin
            s_nxt.rx_pend = 1'b0;
         end else if (!(s_r.lock_v && s_r.lock_b == rx_b)) begin
            // a locked target keeps the frame waiting here
            s_nxt.rx_pend = 1'b0;
            s_nxt.rx_xfer = 1'b1;
            s_nxt.rx_b = rx_b;
            s_nxt.mb[rx_b].id = s_r.rx_id;
            s_nxt.mb[rx_b].data = s_r.rx_data;
            s_nxt.mb[rx_b].len = s_r.rx_len;
            s_nxt.mb[rx_b].ts = s_r.rx_ts;
            s_nxt.mb[rx_b].code = s_r.mb[rx_b].code | cmbm_pkg::C_BUSY;
         end
      end
      // own frames arrive here too; a newer frame replaces a waiting one
      if (rx_valid && s_r.synced) begin
         s_nxt.rx_pend = 1'b1;
         s_nxt.rx_id = rx_id;
         s_nxt.rx_len = rx_len;
         s_nxt.rx_data = rx_data;
         s_nxt.rx_ts = s_r.ts_cap;
      end

      // host reads, data returned next cycle
      if (bus.rd) begin
         if (is_mb) begin
            case (af)
               cmbm_pkg::F_CTRL: begin
                  s_nxt.rdata = {s_r.mb[ab].ts, 8'h00, s_r.mb[ab].code, s_r.mb[ab].len};
                  // a busy buffer is not locked, the host must retry
                  if ((s_r.mb[ab].code & cmbm_pkg::C_BUSY) == 4'h0) begin
                     s_nxt.lock_v = 1'b1;
                     s_nxt.lock_b = ab;
                  end
               end
               cmbm_pkg::F_IDHI: s_nxt.rdata = {19'h0, s_r.mb[ab].id[28:16]};
               cmbm_pkg::F_IDLO: s_nxt.rdata = {16'h0, s_r.mb[ab].id[15:0]};
               cmbm_pkg::F_D0: s_nxt.rdata = s_r.mb[ab].data[63:32];
               cmbm_pkg::F_D1: s_nxt.rdata = s_r.mb[ab].data[31:0];
               default: s_nxt.rdata = 32'h0000_0000;
            endcase
         end else begin
            case (bus.addr)
               cmbm_pkg::A_MCR: s_nxt.rdata = {23'h0, !s_r.synced, s_r.prio, 2'b00,
                                               s_r.lowidx, s_r.halt};
               cmbm_pkg::A_TIMER: begin
                  s_nxt.rdata = {16'h0, s_r.timer};
                  s_nxt.lock_v = 1'b0;
               end
               cmbm_pkg::A_FLAGS: s_nxt.rdata = 32'(s_r.flags);
               cmbm_pkg::A_AMASK: s_nxt.rdata = {3'h0, s_r.amask};
               default: s_nxt.rdata = 32'h0000_0000;
            endcase
         end
      end

      // host writes last, so they override engine updates of the same field
      if (bus.wr) begin
         if (is_mb) begin
            case (af)
               cmbm_pkg::F_CTRL: begin
                  s_nxt.mb[ab].code = bus.wdata[7:4];
                  s_nxt.mb[ab].len = bus.wdata[3:0];
               end
               cmbm_pkg::F_IDHI: s_nxt.mb[ab].id[28:16] = bus.wdata[12:0];
               cmbm_pkg::F_IDLO: s_nxt.mb[ab].id[15:0] = bus.wdata[15:0];
               cmbm_pkg::F_D0: s_nxt.mb[ab].data[63:32] = bus.wdata;
               cmbm_pkg::F_D1: s_nxt.mb[ab].data[31:0] = bus.wdata;
               default: ;
            endcase
         end else if (bus.addr == cmbm_pkg::A_MCR) begin
            s_nxt.halt = bus.wdata[cmbm_pkg::MCR_HALT];
            s_nxt.lowidx = bus.wdata[cmbm_pkg::MCR_LOWIDX];
            s_nxt.prio = bus.wdata[cmbm_pkg::MCR_PRIO +: 4];
         end else if (bus.addr == cmbm_pkg::A_AMASK) begin
            s_nxt.amask = bus.wdata[28:0];
         end
      end
   end

   // buffers clear at reset too; simpler than leaving them unknown
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_r <= '0;
         s_r.halt <= cmbm_pkg::HALT_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bus.rdata = s_r.rdata;
   assign tx_valid = s_r.txs == TX_SEND;
   assign tx_id = s_r.tx_id;
   assign tx_len = s_r.tx_len;
   assign tx_data = s_r.tx_data;
   assign not_ready = !s_r.synced;
endmodule : cmbm_device
`default_nettype wire

/* File: hw/cmbm_pkg.sv */
// constants shared by the message buffer manager ends
// Functional notes
// - host configures while halted, then clears halt
// - host writes every buffer control word at init
// - host sets irq arbitration priority non-zero
// - after halt clears, device synchronises to bus
// - transmit prep: inactive, identifier, data, active
// - active transmit buffers arbitrate when bus idle
// - selected frame copied into serial buffer
// - never send more than eight data bytes
// - on success: time stamp, code, flag
// - control write during selection drops that buffer
// - deactivated during copy: frame not sent
// - deactivated after copy: sent, no update
// - lowest-identifier buffer deactivated may be dropped
// - own transmitted frames are also received
// - receive prep: inactive, identifier, active empty
// - frame stored in lowest matching receive buffer
// - control word read locks buffer, read first
// - timer read releases the locked buffer
// - one lock only; new control read moves it
// - host waits while busy bit set
// - host polls status via flag register
// - received identifier always overwrites buffer identifier
// - frame for locked buffer waits, newest kept
package cmbm_pkg;
   // device register map, word addresses
   localparam logic [7:0] A_MCR = 8'h00;
   localparam logic [7:0] A_TIMER = 8'h01;
   localparam logic [7:0] A_FLAGS = 8'h02;
   localparam logic [7:0] A_AMASK = 8'h03;
   localparam logic [7:0] A_MB_BASE = 8'h10;
   // word inside a buffer, eight words per buffer
   localparam logic [2:0] F_CTRL = 3'h0;
   localparam logic [2:0] F_IDHI = 3'h1;
   localparam logic [2:0] F_IDLO = 3'h2;
   localparam logic [2:0] F_D0 = 3'h3;
   localparam logic [2:0] F_D1 = 3'h4;
   // module_config_reg field positions
   localparam int MCR_HALT = 0;
   localparam int MCR_LOWIDX = 1;
   localparam int MCR_PRIO = 4;
   localparam int MCR_NRDY = 8;
   // buffer codes
   localparam logic [3:0] C_RX_OFF = 4'h0;
   localparam logic [3:0] C_RX_EMPTY = 4'h4;
   localparam logic [3:0] C_RX_FULL = 4'h2;
   localparam logic [3:0] C_RX_OVR = 4'h6;
   localparam logic [3:0] C_BUSY = 4'h1;
   localparam logic [3:0] C_TX_OFF = 4'h8;
   localparam logic [3:0] C_TX_ON = 4'hC;
   localparam logic [3:0] MAX_BYTES = 4'h8;
   // halt reset value, host default priority
   localparam logic HALT_RST = 1'b1;
   localparam logic [3:0] PRIO_DEF = 4'h1;
   // host command port map
   localparam logic [3:0] H_CMD = 4'h0;
   localparam logic [3:0] H_ID = 4'h1;
   localparam logic [3:0] H_CFG = 4'h2;
   localparam logic [3:0] H_D0 = 4'h3;
   localparam logic [3:0] H_D1 = 4'h4;
   localparam logic [3:0] H_RCS = 4'h5;
   localparam logic [3:0] H_RID = 4'h6;
   localparam logic [3:0] H_RD0 = 4'h7;
   localparam logic [3:0] H_RD1 = 4'h8;
   localparam logic [3:0] H_RFLG = 4'h9;
   // host operations
   localparam logic [2:0] OP_INIT = 3'h0;
   localparam logic [2:0] OP_TX = 3'h1;
   localparam logic [2:0] OP_RXARM = 3'h2;
   localparam logic [2:0] OP_RXREAD = 3'h3;
   localparam logic [2:0] OP_FLAGS = 3'h4;
endpackage : cmbm_pkg

/* File: hw/cmbm_bus_if.sv */
// register bus between host controller and buffer manager
`timescale 1ns/1ps
`default_nettype none
interface cmbm_bus_if;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic wr;
   logic rd;
   logic [31:0] rdata;
   modport host (output addr, output wdata, output wr, output rd, input rdata);
   modport dev (input addr, input wdata, input wr, input rd, output rdata);
endinterface : cmbm_bus_if
`default_nettype wire

/* File: hw/cmbm_pick.sv */
// lowest set request wins
`timescale 1ns/1ps
`default_nettype none
module cmbm_pick #(
   parameter int N = 4
) (
   input wire logic [N-1:0] req, // request per entry
   output logic any, // some request set
   output logic [$clog2(N)-1:0] idx // lowest requesting entry
);
   // scan downward so the lowest index is written last
   always_comb begin
      any = 1'b0;
      idx = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            any = 1'b1;
            idx = ($clog2(N))'(i);
         end
      end
   end
endmodule : cmbm_pick
`default_nettype wire

/* File: hw/cmbm_host.sv */
// host controller: runs init, transmit and receive sequences on the bus
`timescale 1ns/1ps
`default_nettype none
module cmbm_host #(
   parameter int NBUF = 4
) (
   input wire logic clk_sys, // system clock
   input wire logic rst, // synchronous reset, active high
   cmbm_bus_if.host bus, // register bus to the device
   input wire logic [3:0] u_addr, // command port address
   input wire logic [31:0] u_wdata, // command port write data
   input wire logic u_wr, // write strobe
   input wire logic u_rd, // read strobe
   output logic [31:0] u_rdata // read data, cycle after strobe
);
   localparam int IW = $clog2(NBUF);

   typedef enum logic [1:0] {H_IDLE, H_GO, H_WAIT, H_CAP} cmbm_hs_t;

   typedef struct packed {
      cmbm_hs_t st;
      logic [2:0] op;
      logic [IW-1:0] bsel;
      logic [3:0] step;
      logic [28:0] a_id;
      logic [3:0] a_len;
      logic a_lowidx;
      logic [3:0] a_prio;
      logic [31:0] a_d0;
      logic [31:0] a_d1;
      logic [31:0] r_cs;
      logic [28:0] r_id;
      logic [31:0] r_d0;
      logic [31:0] r_d1;
      logic [31:0] r_flags;
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
      logic [31:0] urd;
   } cmbm_hst_t;

   cmbm_hst_t s_r;
   cmbm_hst_t s_nxt;

   logic [7:0] mb;
   logic [3:0] prio_eff;
   logic [7:0] t_addr;
   logic [31:0] t_wdata;
   logic t_wr;
   logic t_last;
   assign mb = cmbm_pkg::A_MB_BASE + 8'({s_r.bsel, 3'h0});
   assign prio_eff = (s_r.a_prio == 4'h0) ? cmbm_pkg::PRIO_DEF : s_r.a_prio;

   // one bus access per step of the running operation
   always_comb begin
      t_addr = mb;
      t_wdata = 32'h0000_0000;
      t_wr = 1'b1;
      t_last = 1'b0;
      case (s_r.op)
         cmbm_pkg::OP_INIT: begin
            if (s_r.step == 4'h0) begin
               t_addr = cmbm_pkg::A_MCR;
               t_wdata = {24'h0, prio_eff, 2'b00, s_r.a_lowidx, 1'b1};
            end else if (s_r.step <= NBUF) begin
               t_addr = cmbm_pkg::A_MB_BASE + 8'({s_r.step - 4'h1, 3'h0});
               t_wdata = {24'h0, cmbm_pkg::C_RX_OFF, 4'h0};
            end else if (s_r.step == NBUF + 1) begin
               t_addr = cmbm_pkg::A_AMASK;
               t_wdata = {3'h0, s_r.a_id};
            end else begin
               t_addr = cmbm_pkg::A_MCR;
               t_wdata = {24'h0, prio_eff, 2'b00, s_r.a_lowidx, 1'b0};
               t_last = 1'b1;
            end
         end
         cmbm_pkg::OP_TX, cmbm_pkg::OP_RXARM, cmbm_pkg::OP_RXREAD: begin
            t_wr = s_r.op != cmbm_pkg::OP_RXREAD;
            case (s_r.step)
               4'h0: t_wdata = {24'h0, (s_r.op == cmbm_pkg::OP_TX) ?
                                cmbm_pkg::C_TX_OFF : cmbm_pkg::C_RX_OFF, 4'h0};
               4'h1: begin
                  t_addr = mb + 8'(cmbm_pkg::F_IDHI);
                  t_wdata = {19'h0, s_r.a_id[28:16]};
               end
               4'h2: begin
                  t_addr = mb + 8'(cmbm_pkg::F_IDLO);
                  t_wdata = {16'h0, s_r.a_id[15:0]};
               end
               4'h3: begin
                  t_addr = mb + 8'(cmbm_pkg::F_D0);
                  t_wdata = s_r.a_d0;
                  if (s_r.op == cmbm_pkg::OP_RXARM) begin
                     t_addr = mb;
                     t_wdata = {24'h0, cmbm_pkg::C_RX_EMPTY, 4'h0};
                     t_last = 1'b1;
                  end
               end
               4'h4: begin
                  t_addr = mb + 8'(cmbm_pkg::F_D1);
                  t_wdata = s_r.a_d1;
               end
               default: begin
                  t_addr = (s_r.op == cmbm_pkg::OP_TX) ? mb : cmbm_pkg::A_TIMER;
                  t_wdata = {24'h0, cmbm_pkg::C_TX_ON, s_r.a_len};
                  t_last = 1'b1;
               end
            endcase
         end
         default: begin
            t_addr = cmbm_pkg::A_FLAGS;
            t_wr = 1'b0;
            t_last = 1'b1;
         end
      endcase
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.urd = 32'h0000_0000;
      case (u_addr)
         cmbm_pkg::H_CMD: s_nxt.urd = {31'h0, s_r.st != H_IDLE};
         cmbm_pkg::H_RCS: s_nxt.urd = s_r.r_cs;
         cmbm_pkg::H_RID: s_nxt.urd = {3'h0, s_r.r_id};
         cmbm_pkg::H_RD0: s_nxt.urd = s_r.r_d0;
         cmbm_pkg::H_RD1: s_nxt.urd = s_r.r_d1;
         cmbm_pkg::H_RFLG: s_nxt.urd = s_r.r_flags;
         default: s_nxt.urd = 32'h0000_0000;
      endcase
      if (!u_rd) s_nxt.urd = 32'h0000_0000;
      // arguments may change any time; a running operation reads them live
      if (u_wr) begin
         case (u_addr)
            cmbm_pkg::H_ID: s_nxt.a_id = u_wdata[28:0];
            cmbm_pkg::H_CFG: begin
               s_nxt.a_len = u_wdata[3:0];
               s_nxt.a_lowidx = u_wdata[8];
               s_nxt.a_prio = u_wdata[15:12];
            end
            cmbm_pkg::H_D0: s_nxt.a_d0 = u_wdata;
            cmbm_pkg::H_D1: s_nxt.a_d1 = u_wdata;
            default: ;
         endcase
      end
      case (s_r.st)
         H_IDLE: begin
            if (u_wr && u_addr == cmbm_pkg::H_CMD) begin
               s_nxt.op = u_wdata[2:0];
               s_nxt.bsel = u_wdata[8 +: IW];
               s_nxt.step = 4'h0;
               s_nxt.st = H_GO;
            end
         end
         H_GO: begin
            s_nxt.addr = t_addr;
            s_nxt.wdata = t_wdata;
            s_nxt.wr = t_wr;
            s_nxt.rd = !t_wr;
            s_nxt.st = H_WAIT;
         end
         H_WAIT: begin
            s_nxt.wr = 1'b0;
            s_nxt.rd = 1'b0;
            s_nxt.st = H_CAP;
         end
         H_CAP: begin
            s_nxt.st = H_GO;
            if (s_r.op == cmbm_pkg::OP_FLAGS) s_nxt.r_flags = bus.rdata;
            if (s_r.op == cmbm_pkg::OP_RXREAD) begin
               case (s_r.step)
                  4'h0: s_nxt.r_cs = bus.rdata;
                  4'h1: s_nxt.r_id[28:16] = bus.rdata[12:0];
                  4'h2: s_nxt.r_id[15:0] = bus.rdata[15:0];
                  4'h3: s_nxt.r_d0 = bus.rdata;
                  4'h4: s_nxt.r_d1 = bus.rdata;
                  default: ;
               endcase
            end
            // busy buffer: repeat the control read until it clears
            if (s_r.op == cmbm_pkg::OP_RXREAD && s_r.step == 4'h0 &&
                (bus.rdata[7:4] & cmbm_pkg::C_BUSY) != 4'h0) begin
               s_nxt.step = 4'h0;
            end else if (t_last) begin
               s_nxt.st = H_IDLE;
            end else begin
               s_nxt.step = s_r.step + 4'h1;
            end
         end
         default: s_nxt.st = H_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bus.addr = s_r.addr;
   assign bus.wdata = s_r.wdata;
   assign bus.wr = s_r.wr;
   assign bus.rd = s_r.rd;
   assign u_rdata = s_r.urd;
endmodule : cmbm_host
`default_nettype wire

/* File: dv/cmbm_asserts.sv */
// concurrent checks on the host-device bus and the device link
`timescale 1ns/1ps
`default_nettype none
module cmbm_asserts (
   input wire logic clk_sys, // clock
   input wire logic rst, // reset
   input wire logic [7:0] addr, // bus address
   input wire logic [31:0] wdata, // bus write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   input wire logic tx_valid, // frame on offer
   input wire logic [3:0] tx_len, // length on offer
   input wire logic tx_done, // frame sent
   input wire logic can_idle, // bus free
   input wire logic not_ready // not synchronised
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // write of a code into some buffer control word
   sequence s_ctl(logic [3:0] c);
      wr && addr >= cmbm_pkg::A_MB_BASE && addr[2:0] == cmbm_pkg::F_CTRL && wdata[7:4] == c;
   endsequence
   // config write with a given halt bit
   sequence s_mcr(logic h);
      wr && addr == cmbm_pkg::A_MCR && wdata[0] == h;
   endsequence
   halt_release_a: assert property (s_mcr(1'b1) |-> ##[4:80] s_mcr(1'b0))
      else $error("halt not released after init");
   sync_wait_a: assert property ($fell(not_ready) |-> $past(can_idle) || $past(can_idle, 2))
      else $error("synchronised without idle bus");
   tx_prep_a: assert property (s_ctl(cmbm_pkg::C_TX_OFF) |-> ##[10:60] s_ctl(cmbm_pkg::C_TX_ON))
      else $error("transmit buffer not activated last");
   arb_idle_a: assert property ($rose(tx_valid) |-> $past(can_idle, 3))
      else $error("frame offered without idle bus");
   tx_hold_a: assert property (tx_valid && !tx_done |=> tx_valid && $stable(tx_len))
      else $error("frame dropped before done");
   len_cap_a: assert property (tx_valid |-> tx_len <= cmbm_pkg::MAX_BYTES)
      else $error("length above eight");
   tx_end_a: assert property (tx_valid && tx_done |=> !tx_valid)
      else $error("frame still offered after done");
   lock_release_a: assert property (rd && addr >= cmbm_pkg::A_MB_BASE && addr[2:0] == 3'h0
      |-> ##[1:90] (rd && addr == cmbm_pkg::A_TIMER)) else $error("lock never released");
endmodule : cmbm_asserts
`default_nettype wire

/* File: dv/tb_can_message_buffer_manager.sv */
// bench driving the host command port and the device link
`timescale 1ns/1ps
`default_nettype none
module tb_can_message_buffer_manager;
   logic clk_sys = 1'b0, rst = 1'b1, u_wr = 1'b0, u_rd = 1'b0, tx_valid, not_ready;
   logic can_idle = 1'b0, can_id_start = 1'b0, tx_done = 1'b0, rx_valid = 1'b0;
   logic [3:0] u_addr = 4'h0, rx_len = 4'h0, tx_len;
   logic [31:0] u_wdata = 32'h0, u_rdata, d;
   logic [28:0] rx_id = 29'h0, tx_id;
   logic [63:0] rx_data = 64'h0, tx_data;
   int errors = 0, compares = 0;
   always #5 clk_sys = ~clk_sys;
   cmbm_bus_if bus_i ();
   cmbm_host u_cmbm_host (.clk_sys(clk_sys), .rst(rst), .bus(bus_i), .u_addr(u_addr),
      .u_wdata(u_wdata), .u_wr(u_wr), .u_rd(u_rd), .u_rdata(u_rdata));
   cmbm_device u_cmbm_device (.clk_sys(clk_sys), .rst(rst), .bus(bus_i), .can_idle(can_idle),
      .can_id_start(can_id_start), .tx_valid(tx_valid), .tx_id(tx_id), .tx_len(tx_len),
      .tx_data(tx_data), .tx_done(tx_done), .rx_valid(rx_valid), .rx_id(rx_id),
      .rx_len(rx_len), .rx_data(rx_data), .not_ready(not_ready));
   cmbm_asserts u_cmbm_asserts (.clk_sys(clk_sys), .rst(rst), .addr(bus_i.addr),
      .wdata(bus_i.wdata), .wr(bus_i.wr), .rd(bus_i.rd), .tx_valid(tx_valid), .tx_len(tx_len),
      .tx_done(tx_done), .can_idle(can_idle), .not_ready(not_ready));
   task automatic report_and_stop();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // one-cycle write strobe, dropped at the next edge
   task automatic hw(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      u_addr <= a;
      u_wdata <= v;
      u_wr <= 1'b1;
      @(posedge clk_sys);
      u_wr <= 1'b0;
   endtask : hw
   // read data only stands in the cycle after the strobe
   task automatic hr(input logic [3:0] a);
      @(posedge clk_sys);
      u_addr <= a;
      u_rd <= 1'b1;
      @(posedge clk_sys);
      u_rd <= 1'b0;
      #1 d = u_rdata;
   endtask : hr
   // issue a command and poll busy, bounded so a hang ends the run
   task automatic run(input logic [2:0] op, input logic [1:0] b);
      hw(cmbm_pkg::H_CMD, {22'h0, b, 5'h0, op});
      for (int i = 0; i < 100; i++) begin
         hr(cmbm_pkg::H_CMD);
         if (d[0] === 1'b0) return;
      end
      chk("host idle", 64'h0, 64'h1);
      report_and_stop();
   endtask : run
   task automatic wait_tx();
      for (int i = 0; i < 50; i++) begin
         if (tx_valid === 1'b1) return;
         @(posedge clk_sys);
      end
      chk("tx_valid", 64'h1, 64'h0);
      report_and_stop();
   endtask : wait_tx
   // main sequence: init, transmit with long length, receive into lowest match
   initial begin
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      hw(cmbm_pkg::H_ID, 32'h1FFFFF00);
      hw(cmbm_pkg::H_CFG, 32'h3000);
      run(cmbm_pkg::OP_INIT, 2'h0);
      chk("not_ready", 64'h1, {63'h0, not_ready});
      @(posedge clk_sys);
      can_idle <= 1'b1;
      repeat (4) @(posedge clk_sys);
      can_idle <= 1'b0;
      chk("not_ready", 64'h0, {63'h0, not_ready});
      $display("test init done");
      hw(cmbm_pkg::H_ID, 32'h1ABCDE12);
      hw(cmbm_pkg::H_CFG, 32'h300A);
      hw(cmbm_pkg::H_D0, 32'h11223344);
      hw(cmbm_pkg::H_D1, 32'h55667788);
      run(cmbm_pkg::OP_TX, 2'h1);
      @(posedge clk_sys);
      can_idle <= 1'b1;
      wait_tx();
      chk("tx_id", 64'h1ABCDE12, {35'h0, tx_id});
      chk("tx_len", 64'h8, {60'h0, tx_len});
      chk("tx_data", 64'h1122334455667788, tx_data);
      @(posedge clk_sys);
      can_idle <= 1'b0;
      can_id_start <= 1'b1;
      @(posedge clk_sys);
      can_id_start <= 1'b0;
      tx_done <= 1'b1;
      @(posedge clk_sys);
      tx_done <= 1'b0;
      run(cmbm_pkg::OP_FLAGS, 2'h0);
      hr(cmbm_pkg::H_RFLG);
      chk("tx flag", 64'h1, {63'h0, d[1]});
      run(cmbm_pkg::OP_RXREAD, 2'h1);
      hr(cmbm_pkg::H_RCS);
      chk("tx code", {60'h0, cmbm_pkg::C_TX_OFF}, {60'h0, d[7:4]});
      $display("test tx done");
      hw(cmbm_pkg::H_ID, 32'h123);
      run(cmbm_pkg::OP_RXARM, 2'h3);
      run(cmbm_pkg::OP_RXARM, 2'h2);
      @(posedge clk_sys);
      rx_id <= 29'h1ED;
      rx_len <= 4'h5;
      rx_data <= 64'hA1B2C3D4E5F60718;
      rx_valid <= 1'b1;
      @(posedge clk_sys);
      rx_valid <= 1'b0;
      repeat (4) @(posedge clk_sys);
      run(cmbm_pkg::OP_RXREAD, 2'h2);
      hr(cmbm_pkg::H_RCS);
      chk("rx ctrl", {56'h0, cmbm_pkg::C_RX_FULL, 4'h5}, {56'h0, d[7:0]});
      hr(cmbm_pkg::H_RD0);
      chk("rx data", 64'hA1B2C3D4, {32'h0, d});
      hr(cmbm_pkg::H_RID);
      chk("rx id", 64'h1ED, {35'h0, d[28:0]});
      run(cmbm_pkg::OP_RXREAD, 2'h3);
      hr(cmbm_pkg::H_RCS);
      chk("rx other", {60'h0, cmbm_pkg::C_RX_EMPTY}, {60'h0, d[7:4]});
      $display("test rx done");
      report_and_stop();
   end
endmodule : tb_can_message_buffer_manager
`default_nettype wire
